// >>> rtl/iosad_pkg.sv
// package: register map, field layouts and command encodings of the i/o space decoder
package iosad_pkg;

  // access kinds issued by the core
  typedef enum logic [2:0] {
    IOSAD_OP_NONE = 3'h0,
    IOSAD_OP_PORT_READ = 3'h1,
    IOSAD_OP_PORT_WRITE = 3'h2,
    IOSAD_OP_SET_BIT = 3'h3,
    IOSAD_OP_CLEAR_BIT = 3'h4,
    IOSAD_OP_TEST_BIT = 3'h5,
    IOSAD_OP_MEM_READ = 3'h6,
    IOSAD_OP_MEM_WRITE = 3'h7
  } iosad_op_t;

  // one request from the core
  typedef struct packed {
    iosad_op_t op;
    logic [8:0] addr;
    logic [2:0] bit_sel;
    logic [7:0] wdata;
  } iosad_req_t;

  // one answer to the core
  typedef struct packed {
    logic valid;
    logic [7:0] rdata;
    logic bit_value;
    logic hit;
  } iosad_rsp_t;

  localparam logic [8:0] IOSAD_DATA_OFFSET = 9'h020;
  localparam logic [8:0] IOSAD_EXT_LOW = 9'h060;
  localparam logic [8:0] IOSAD_EXT_HIGH = 9'h1FF;
  localparam logic [5:0] IOSAD_PORT_TOP = 6'h3F;
  localparam logic [5:0] IOSAD_BIT_TOP = 6'h1F;

  // i/o offsets
  localparam logic [5:0] IOSAD_PORT_B_PIN_INPUT = 6'h03;
  localparam logic [5:0] IOSAD_PORT_B_DIRECTION = 6'h04;
  localparam logic [5:0] IOSAD_PORT_B_OUTPUT = 6'h05;
  localparam logic [5:0] IOSAD_PORT_C_PIN_INPUT = 6'h06;
  localparam logic [5:0] IOSAD_PORT_C_DIRECTION = 6'h07;
  localparam logic [5:0] IOSAD_PORT_C_OUTPUT = 6'h08;
  localparam logic [5:0] IOSAD_PORT_D_PIN_INPUT = 6'h09;
  localparam logic [5:0] IOSAD_PORT_D_DIRECTION = 6'h0A;
  localparam logic [5:0] IOSAD_PORT_D_OUTPUT = 6'h0B;
  localparam logic [5:0] IOSAD_PORT_E_PIN_INPUT = 6'h0C;
  localparam logic [5:0] IOSAD_PORT_E_DIRECTION = 6'h0D;
  localparam logic [5:0] IOSAD_PORT_E_OUTPUT = 6'h0E;
  localparam logic [5:0] IOSAD_PORT_F_PIN_INPUT = 6'h0F;
  localparam logic [5:0] IOSAD_PORT_F_DIRECTION = 6'h10;
  localparam logic [5:0] IOSAD_PORT_F_OUTPUT = 6'h11;
  localparam logic [5:0] IOSAD_TIMER0_FLAGS = 6'h15;
  localparam logic [5:0] IOSAD_TIMER1_FLAGS = 6'h16;
  localparam logic [5:0] IOSAD_TIMER4_FLAGS = 6'h19;
  localparam logic [5:0] IOSAD_EEPROM_DATA = 6'h20;
  localparam logic [5:0] IOSAD_EEPROM_ADDRESS_LOW = 6'h21;
  localparam logic [5:0] IOSAD_EEPROM_ADDRESS_HIGH = 6'h22;
  localparam logic [5:0] IOSAD_GENERAL_TIMER_CONTROL = 6'h23;
  localparam logic [5:0] IOSAD_TIMER0_CONTROL_A = 6'h24;
  localparam logic [5:0] IOSAD_TIMER0_CONTROL_B = 6'h25;
  localparam logic [5:0] IOSAD_TIMER0_COUNT = 6'h26;
  localparam logic [5:0] IOSAD_TIMER0_COMPARE_A = 6'h27;
  localparam logic [5:0] IOSAD_TIMER0_COMPARE_B = 6'h28;
  localparam logic [5:0] IOSAD_PLL_CONTROL_STATUS = 6'h29;
  localparam logic [5:0] IOSAD_GENERAL_PURPOSE_ONE = 6'h2A;
  localparam logic [5:0] IOSAD_GENERAL_PURPOSE_TWO = 6'h2B;
  localparam logic [5:0] IOSAD_SERIAL_PERIPH_CONTROL = 6'h2C;
  localparam logic [5:0] IOSAD_SERIAL_PERIPH_STATUS = 6'h2D;
  localparam logic [5:0] IOSAD_SERIAL_PERIPH_DATA = 6'h2E;
  localparam logic [5:0] IOSAD_COMPARATOR_CONTROL_STATUS = 6'h30;
  localparam logic [5:0] IOSAD_DEBUG_MONITOR_DATA = 6'h31;
  localparam logic [5:0] IOSAD_PLL_FREQUENCY_CONTROL = 6'h32;
  localparam logic [5:0] IOSAD_SLEEP_MODE_CONTROL = 6'h33;

  // implemented bit masks, reserved bits are zero
  localparam logic [7:0] IOSAD_MASK_PORT_B = 8'hFF;
  localparam logic [7:0] IOSAD_MASK_PORT_C = 8'hC0;
  localparam logic [7:0] IOSAD_MASK_PORT_D = 8'hFF;
  localparam logic [7:0] IOSAD_MASK_PORT_E = 8'h44;
  localparam logic [7:0] IOSAD_MASK_PORT_F = 8'hF3;
  localparam logic [7:0] IOSAD_MASK_TIMER0_FLAGS = 8'h07;
  localparam logic [7:0] IOSAD_MASK_TIMER1_FLAGS = 8'h2F;
  localparam logic [7:0] IOSAD_MASK_TIMER4_FLAGS = 8'hE4;
  localparam logic [7:0] IOSAD_MASK_FULL = 8'hFF;
  localparam logic [7:0] IOSAD_MASK_EEPROM_ADDRESS_HIGH = 8'h03;
  localparam logic [7:0] IOSAD_MASK_GENERAL_TIMER_CONTROL = 8'h83;
  localparam logic [7:0] IOSAD_MASK_TIMER0_CONTROL_A = 8'hF3;
  localparam logic [7:0] IOSAD_MASK_TIMER0_CONTROL_B = 8'hCF;
  localparam logic [7:0] IOSAD_MASK_PLL_CONTROL_STATUS = 8'h13;
  localparam logic [7:0] IOSAD_MASK_SERIAL_PERIPH_STATUS = 8'hC1;
  localparam logic [7:0] IOSAD_MASK_SLEEP_MODE_CONTROL = 8'h0F;

  // bits that software can write, status bits driven by peripherals are excluded except comparator flag bit 4 (0x10)
  localparam logic [7:0] IOSAD_WMASK_PLL_CONTROL_STATUS = 8'h12;
  localparam logic [7:0] IOSAD_WMASK_SERIAL_PERIPH_STATUS = 8'h01;
  localparam logic [7:0] IOSAD_WMASK_COMPARATOR = 8'hDF;
  // write-one-to-clear bits in mixed registers
  localparam logic [7:0] IOSAD_W1C_COMPARATOR = 8'h10;
  localparam logic [7:0] IOSAD_W1C_SERIAL_PERIPH_STATUS = 8'hC0;

  localparam logic [7:0] IOSAD_RESET_VALUE = 8'h00;
  localparam int IOSAD_STORE_COUNT = 32;

endpackage : iosad_pkg

// >>> rtl/iosad_decoder.sv
// i/o space address decoder with register storage, bit access and flag clearing
//
// Contract
// - set and clear bit on addresses 00-1F
// - return one selected bit for skip tests
// - writing one clears status flags
// - bit operations rewrite whole register, clearing flags
// - bit operations ignored above address 1F
// - port access uses i/o addresses 00-3F
// - data address equals i/o address plus 20
// - extended space reachable only by loads/stores
`timescale 1ns/1ps
`default_nettype none

module iosad_decoder #(
  parameter int DATA_W = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // core request and answer
  input wire iosad_pkg::iosad_req_t req,
  output iosad_pkg::iosad_rsp_t rsp,
  // extended space pass-through
  output logic ext_sel,
  output logic ext_we,
  output logic [8:0] ext_addr,
  output logic [7:0] ext_wdata,
  input wire logic [7:0] ext_rdata,
  // port pins, asynchronous
  input wire logic [7:0] pin_b,
  input wire logic [7:0] pin_c,
  input wire logic [7:0] pin_d,
  input wire logic [7:0] pin_e,
  input wire logic [7:0] pin_f,
  // peripheral flag set pulses and status levels
  input wire logic [7:0] timer0_flag_set,
  input wire logic [7:0] timer1_flag_set,
  input wire logic [7:0] timer4_flag_set,
  input wire logic [7:0] comparator_flag_set,
  input wire logic [7:0] serial_flag_set,
  input wire logic comparator_out,
  input wire logic pll_locked,
  input wire logic [7:0] serial_rx_data,
  input wire logic serial_rx_load,
  // stored register outputs
  output logic [7:0] port_b_dir,
  output logic [7:0] port_b_out,
  output logic [7:0] port_c_dir,
  output logic [7:0] port_c_out,
  output logic [7:0] port_d_dir,
  output logic [7:0] port_d_out,
  output logic [7:0] port_e_dir,
  output logic [7:0] port_e_out,
  output logic [7:0] port_f_dir,
  output logic [7:0] port_f_out,
  output logic [255:0] reg_image
);

  if (DATA_W != 8) begin : g_width_check
    $error("iosad_decoder serves 8-bit data only");
  end

  localparam int IOSAD_COUNT_MSB = iosad_pkg::IOSAD_STORE_COUNT * 2 - 1;

  typedef struct packed {
    logic [2:0][39:0] pin_sync;
    logic [39:0] pin_stable;
    logic [IOSAD_COUNT_MSB:0][7:0] store;
    iosad_pkg::iosad_rsp_t rsp;
  } iosad_state_t;

  iosad_state_t s_q;
  iosad_state_t s_d;

  // index map: 0..31 low i/o, 32..63 high i/o
  function automatic logic [7:0] iosad_mask(input logic [5:0] a);
    unique case (a)
      iosad_pkg::IOSAD_PORT_B_DIRECTION, iosad_pkg::IOSAD_PORT_B_OUTPUT,
      iosad_pkg::IOSAD_PORT_D_DIRECTION, iosad_pkg::IOSAD_PORT_D_OUTPUT: iosad_mask = iosad_pkg::IOSAD_MASK_PORT_B;
      iosad_pkg::IOSAD_PORT_C_DIRECTION, iosad_pkg::IOSAD_PORT_C_OUTPUT: iosad_mask = iosad_pkg::IOSAD_MASK_PORT_C;
      iosad_pkg::IOSAD_PORT_E_DIRECTION, iosad_pkg::IOSAD_PORT_E_OUTPUT: iosad_mask = iosad_pkg::IOSAD_MASK_PORT_E;
      iosad_pkg::IOSAD_PORT_F_DIRECTION, iosad_pkg::IOSAD_PORT_F_OUTPUT: iosad_mask = iosad_pkg::IOSAD_MASK_PORT_F;
      iosad_pkg::IOSAD_TIMER0_FLAGS: iosad_mask = iosad_pkg::IOSAD_MASK_TIMER0_FLAGS;
      iosad_pkg::IOSAD_TIMER1_FLAGS: iosad_mask = iosad_pkg::IOSAD_MASK_TIMER1_FLAGS;
      iosad_pkg::IOSAD_TIMER4_FLAGS: iosad_mask = iosad_pkg::IOSAD_MASK_TIMER4_FLAGS;
      iosad_pkg::IOSAD_EEPROM_DATA, iosad_pkg::IOSAD_EEPROM_ADDRESS_LOW, iosad_pkg::IOSAD_TIMER0_COUNT,
      iosad_pkg::IOSAD_TIMER0_COMPARE_A, iosad_pkg::IOSAD_TIMER0_COMPARE_B,
      iosad_pkg::IOSAD_GENERAL_PURPOSE_ONE, iosad_pkg::IOSAD_GENERAL_PURPOSE_TWO,
      iosad_pkg::IOSAD_SERIAL_PERIPH_CONTROL, iosad_pkg::IOSAD_SERIAL_PERIPH_DATA,
      iosad_pkg::IOSAD_COMPARATOR_CONTROL_STATUS, iosad_pkg::IOSAD_DEBUG_MONITOR_DATA,
      iosad_pkg::IOSAD_PLL_FREQUENCY_CONTROL: iosad_mask = iosad_pkg::IOSAD_MASK_FULL;
      iosad_pkg::IOSAD_EEPROM_ADDRESS_HIGH: iosad_mask = iosad_pkg::IOSAD_MASK_EEPROM_ADDRESS_HIGH;
      iosad_pkg::IOSAD_GENERAL_TIMER_CONTROL: iosad_mask = iosad_pkg::IOSAD_MASK_GENERAL_TIMER_CONTROL;
      iosad_pkg::IOSAD_TIMER0_CONTROL_A: iosad_mask = iosad_pkg::IOSAD_MASK_TIMER0_CONTROL_A;
      iosad_pkg::IOSAD_TIMER0_CONTROL_B: iosad_mask = iosad_pkg::IOSAD_MASK_TIMER0_CONTROL_B;
      iosad_pkg::IOSAD_PLL_CONTROL_STATUS: iosad_mask = iosad_pkg::IOSAD_MASK_PLL_CONTROL_STATUS;
      iosad_pkg::IOSAD_SERIAL_PERIPH_STATUS: iosad_mask = iosad_pkg::IOSAD_MASK_SERIAL_PERIPH_STATUS;
      iosad_pkg::IOSAD_SLEEP_MODE_CONTROL: iosad_mask = iosad_pkg::IOSAD_MASK_SLEEP_MODE_CONTROL;
      default: iosad_mask = 8'h00;
    endcase
  endfunction : iosad_mask

  // which stored bits software may write directly
  function automatic logic [7:0] iosad_wmask(input logic [5:0] a);
    unique case (a)
      iosad_pkg::IOSAD_TIMER0_FLAGS, iosad_pkg::IOSAD_TIMER1_FLAGS,
      iosad_pkg::IOSAD_TIMER4_FLAGS: iosad_wmask = 8'h00;
      iosad_pkg::IOSAD_PLL_CONTROL_STATUS: iosad_wmask = iosad_pkg::IOSAD_WMASK_PLL_CONTROL_STATUS;
      iosad_pkg::IOSAD_SERIAL_PERIPH_STATUS: iosad_wmask = iosad_pkg::IOSAD_WMASK_SERIAL_PERIPH_STATUS;
      iosad_pkg::IOSAD_COMPARATOR_CONTROL_STATUS: iosad_wmask = iosad_pkg::IOSAD_WMASK_COMPARATOR;
      default: iosad_wmask = iosad_mask(a);
    endcase
  endfunction : iosad_wmask

  // which stored bits clear on a written one
  function automatic logic [7:0] iosad_w1c(input logic [5:0] a);
    unique case (a)
      iosad_pkg::IOSAD_TIMER0_FLAGS, iosad_pkg::IOSAD_TIMER1_FLAGS,
      iosad_pkg::IOSAD_TIMER4_FLAGS: iosad_w1c = iosad_mask(a);
      iosad_pkg::IOSAD_SERIAL_PERIPH_STATUS: iosad_w1c = iosad_pkg::IOSAD_W1C_SERIAL_PERIPH_STATUS;
      iosad_pkg::IOSAD_COMPARATOR_CONTROL_STATUS: iosad_w1c = iosad_pkg::IOSAD_W1C_COMPARATOR;
      default: iosad_w1c = 8'h00;
    endcase
  endfunction : iosad_w1c

  logic [39:0] pin_raw;
  logic [5:0] io_addr;
  logic io_hit;
  logic is_write;
  logic is_read;
  logic [7:0] cur;
  logic [7:0] wval;
  logic [7:0] bit_onehot;

  assign pin_raw = {pin_f, pin_e, pin_d, pin_c, pin_b};

  always_comb begin
    io_addr = 6'h00;
    io_hit = 1'b0;
    ext_sel = 1'b0;
    unique case (req.op)
      iosad_pkg::IOSAD_OP_PORT_READ, iosad_pkg::IOSAD_OP_PORT_WRITE: begin
        io_addr = req.addr[5:0];
        io_hit = (req.addr[8:6] == 3'h0);
      end
      iosad_pkg::IOSAD_OP_SET_BIT, iosad_pkg::IOSAD_OP_CLEAR_BIT, iosad_pkg::IOSAD_OP_TEST_BIT: begin
        io_addr = req.addr[5:0];
        io_hit = (req.addr[8:5] == 4'h0);
      end
      iosad_pkg::IOSAD_OP_MEM_READ, iosad_pkg::IOSAD_OP_MEM_WRITE: begin
        io_addr = 6'(req.addr - iosad_pkg::IOSAD_DATA_OFFSET);
        io_hit = (req.addr >= iosad_pkg::IOSAD_DATA_OFFSET) && (req.addr < iosad_pkg::IOSAD_EXT_LOW);
        ext_sel = (req.addr >= iosad_pkg::IOSAD_EXT_LOW) && (req.addr <= iosad_pkg::IOSAD_EXT_HIGH);
      end
      default: ;
    endcase
  end

  assign ext_we = ext_sel && (req.op == iosad_pkg::IOSAD_OP_MEM_WRITE);
  assign ext_addr = req.addr;
  assign ext_wdata = req.wdata;
  assign is_write = (req.op == iosad_pkg::IOSAD_OP_PORT_WRITE) || (req.op == iosad_pkg::IOSAD_OP_MEM_WRITE) ||
                    (req.op == iosad_pkg::IOSAD_OP_SET_BIT) || (req.op == iosad_pkg::IOSAD_OP_CLEAR_BIT);
  assign is_read = (req.op != iosad_pkg::IOSAD_OP_NONE) && !is_write;
  assign bit_onehot = 8'(8'h01 << req.bit_sel);

  // current readable value of the addressed register
  always_comb begin
    cur = s_q.store[io_addr] & iosad_mask(io_addr);
    unique case (io_addr)
      iosad_pkg::IOSAD_PORT_B_PIN_INPUT: cur = s_q.pin_stable[7:0];
      iosad_pkg::IOSAD_PORT_C_PIN_INPUT: cur = s_q.pin_stable[15:8] & iosad_pkg::IOSAD_MASK_PORT_C;
      iosad_pkg::IOSAD_PORT_D_PIN_INPUT: cur = s_q.pin_stable[23:16];
      iosad_pkg::IOSAD_PORT_E_PIN_INPUT: cur = s_q.pin_stable[31:24] & iosad_pkg::IOSAD_MASK_PORT_E;
      iosad_pkg::IOSAD_PORT_F_PIN_INPUT: cur = s_q.pin_stable[39:32] & iosad_pkg::IOSAD_MASK_PORT_F;
      default: ;
    endcase
  end

  // bit ops write back the whole read value
  always_comb begin
    unique case (req.op)
      iosad_pkg::IOSAD_OP_SET_BIT: wval = cur | bit_onehot;
      iosad_pkg::IOSAD_OP_CLEAR_BIT: wval = cur & ~bit_onehot;
      default: wval = req.wdata;
    endcase
  end

  always_comb begin
    logic [7:0] old;
    logic [7:0] wm;
    logic [7:0] cm;
    old = 8'h00;
    wm = 8'h00;
    cm = 8'h00;
    s_d = s_q;
    // pin sampling: three stages, change taken when second and third agree
    s_d.pin_sync[0] = pin_raw;
    s_d.pin_sync[1] = s_q.pin_sync[0];
    s_d.pin_sync[2] = s_q.pin_sync[1];
    for (int i = 0; i < 40; i++) begin
      if (s_q.pin_sync[1][i] == s_q.pin_sync[2][i]) begin
        s_d.pin_stable[i] = s_q.pin_sync[2][i];
      end
    end
    if (is_write && io_hit) begin
      old = s_q.store[io_addr];
      wm = iosad_wmask(io_addr);
      cm = iosad_w1c(io_addr);
      s_d.store[io_addr] = ((old & ~wm) | (wval & wm)) & ~(wval & cm) & iosad_mask(io_addr);
    end
    // hardware set wins over a same-cycle clear
    s_d.store[iosad_pkg::IOSAD_TIMER0_FLAGS] = s_d.store[iosad_pkg::IOSAD_TIMER0_FLAGS] |
                                               (timer0_flag_set & iosad_pkg::IOSAD_MASK_TIMER0_FLAGS);
    s_d.store[iosad_pkg::IOSAD_TIMER1_FLAGS] = s_d.store[iosad_pkg::IOSAD_TIMER1_FLAGS] |
                                               (timer1_flag_set & iosad_pkg::IOSAD_MASK_TIMER1_FLAGS);
    s_d.store[iosad_pkg::IOSAD_TIMER4_FLAGS] = s_d.store[iosad_pkg::IOSAD_TIMER4_FLAGS] |
                                               (timer4_flag_set & iosad_pkg::IOSAD_MASK_TIMER4_FLAGS);
    s_d.store[iosad_pkg::IOSAD_COMPARATOR_CONTROL_STATUS] =
      (s_d.store[iosad_pkg::IOSAD_COMPARATOR_CONTROL_STATUS] | (comparator_flag_set & iosad_pkg::IOSAD_W1C_COMPARATOR) |
       8'h20) & ~(comparator_out ? 8'h00 : 8'h20);
    s_d.store[iosad_pkg::IOSAD_SERIAL_PERIPH_STATUS] = s_d.store[iosad_pkg::IOSAD_SERIAL_PERIPH_STATUS] |
      (serial_flag_set & iosad_pkg::IOSAD_W1C_SERIAL_PERIPH_STATUS);
    s_d.store[iosad_pkg::IOSAD_PLL_CONTROL_STATUS][0] = pll_locked;
    if (serial_rx_load) begin
      s_d.store[iosad_pkg::IOSAD_SERIAL_PERIPH_DATA] = serial_rx_data;
    end
    // answer, registered one cycle after the request
    s_d.rsp.valid = (req.op != iosad_pkg::IOSAD_OP_NONE);
    s_d.rsp.hit = io_hit || ext_sel;
    s_d.rsp.rdata = 8'h00;
    s_d.rsp.bit_value = 1'b0;
    if (is_read && io_hit) begin
      s_d.rsp.rdata = cur;
    end else if (is_read && ext_sel) begin
      s_d.rsp.rdata = ext_rdata;
    end
    if (req.op == iosad_pkg::IOSAD_OP_TEST_BIT && io_hit) begin
      s_d.rsp.bit_value = cur[req.bit_sel];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign rsp = s_q.rsp;
  assign port_b_dir = s_q.store[iosad_pkg::IOSAD_PORT_B_DIRECTION];
  assign port_b_out = s_q.store[iosad_pkg::IOSAD_PORT_B_OUTPUT];
  assign port_c_dir = s_q.store[iosad_pkg::IOSAD_PORT_C_DIRECTION];
  assign port_c_out = s_q.store[iosad_pkg::IOSAD_PORT_C_OUTPUT];
  assign port_d_dir = s_q.store[iosad_pkg::IOSAD_PORT_D_DIRECTION];
  assign port_d_out = s_q.store[iosad_pkg::IOSAD_PORT_D_OUTPUT];
  assign port_e_dir = s_q.store[iosad_pkg::IOSAD_PORT_E_DIRECTION];
  assign port_e_out = s_q.store[iosad_pkg::IOSAD_PORT_E_OUTPUT];
  assign port_f_dir = s_q.store[iosad_pkg::IOSAD_PORT_F_DIRECTION];
  assign port_f_out = s_q.store[iosad_pkg::IOSAD_PORT_F_OUTPUT];
  assign reg_image = s_q.store[63:32];

endmodule : iosad_decoder

`default_nettype wire

// >>> dv/iosad_core_model.sv
// core-side requester model: issues one i/o access at a time and collects the answer
`timescale 1ns/1ps
`default_nettype none

module iosad_core_model (
  // clock
  input wire logic core_clk,
  // request out, answer in
  output iosad_pkg::iosad_req_t req,
  input wire iosad_pkg::iosad_rsp_t rsp
);
  initial req = '0;

  // idle gap, then one request held through its taking edge; answer looked for after each edge
  task automatic access(input iosad_pkg::iosad_op_t op, input logic [8:0] addr, input logic [2:0] bsel,
                        input logic [7:0] wdata, input int gap, output iosad_pkg::iosad_rsp_t ans, output bit ok);
    ok = 1'b0;
    ans = '0;
    repeat (gap + 1) @(posedge core_clk);
    req <= '{op: op, addr: addr, bit_sel: bsel, wdata: wdata};
    for (int n = 0; n < 4 && !ok; n++) begin
      @(posedge core_clk);
      req <= '0;
      #1;
      ok = (rsp.valid === 1'b1);
      ans = rsp;
    end
  endtask : access
endmodule : iosad_core_model
`default_nettype wire

// >>> dv/iosad_decoder_monitor.sv
// checker: timing and mapping relations at the decoder ports
`timescale 1ns/1ps
`default_nettype none

module iosad_decoder_monitor (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // core side
  input wire iosad_pkg::iosad_req_t req,
  input wire iosad_pkg::iosad_rsp_t rsp,
  // extended space
  input wire logic ext_sel,
  input wire logic ext_we,
  input wire logic [8:0] ext_addr,
  input wire logic [7:0] ext_wdata,
  input wire logic [7:0] ext_rdata,
  // stored values
  input wire logic [7:0] port_d_out,
  input wire logic [255:0] reg_image
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  logic is_mem;
  logic is_bit;
  assign is_mem = req.op == iosad_pkg::IOSAD_OP_MEM_READ || req.op == iosad_pkg::IOSAD_OP_MEM_WRITE;
  assign is_bit = req.op inside {iosad_pkg::IOSAD_OP_SET_BIT, iosad_pkg::IOSAD_OP_CLEAR_BIT, iosad_pkg::IOSAD_OP_TEST_BIT};

  sequence s_take(o, a);
    clk_en && req.op == o && req.addr == a;
  endsequence
  sequence s_ext_rd;
    clk_en && req.op == iosad_pkg::IOSAD_OP_MEM_READ && req.addr >= 9'h060;
  endsequence

  property p_ext_sel;
    ext_sel == (is_mem && req.addr >= 9'h060);
  endproperty
  a_ext_sel: assert property (p_ext_sel) else $error("extended select wrong");
  property p_ext_path;
    ext_sel |-> ext_addr == req.addr && ext_we == (req.op == iosad_pkg::IOSAD_OP_MEM_WRITE) && (!ext_we || ext_wdata == req.wdata);
  endproperty
  a_ext_path: assert property (p_ext_path) else $error("extended pass-through wrong");
  property p_answer;
    clk_en && req.op != iosad_pkg::IOSAD_OP_NONE |=> rsp.valid;
  endproperty
  a_answer: assert property (p_answer) else $error("request not answered");
  property p_quiet;
    clk_en && req.op == iosad_pkg::IOSAD_OP_NONE |=> !rsp.valid;
  endproperty
  a_quiet: assert property (p_quiet) else $error("answer without request");
  property p_bit_refuse;
    clk_en && is_bit && req.addr > 9'h01F |=> !rsp.hit;
  endproperty
  a_bit_refuse: assert property (p_bit_refuse) else $error("bit op above low range hit");
  property p_ext_read;
    s_ext_rd |=> rsp.hit && rsp.rdata == $past(ext_rdata);
  endproperty
  a_ext_read: assert property (p_ext_read) else $error("extended read data wrong");
  property p_port_write;
    s_take(iosad_pkg::IOSAD_OP_PORT_WRITE, 9'h00B) |=> port_d_out == $past(req.wdata);
  endproperty
  a_port_write: assert property (p_port_write) else $error("port write not stored");
  property p_mem_write;
    s_take(iosad_pkg::IOSAD_OP_MEM_WRITE, 9'h04B) |=> reg_image[95:88] == $past(req.wdata);
  endproperty
  a_mem_write: assert property (p_mem_write) else $error("data space write misplaced");
  property p_clear;
    s_take(iosad_pkg::IOSAD_OP_CLEAR_BIT, 9'h00B) |=> port_d_out == ($past(port_d_out) & ~(8'h01 << $past(req.bit_sel)));
  endproperty
  a_clear: assert property (p_clear) else $error("clear bit wrong");
  property p_freeze;
    !clk_en |=> $stable(rsp) && $stable(reg_image) && $stable(port_d_out);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved with clock enable low");
endmodule : iosad_decoder_monitor

bind iosad_decoder iosad_decoder_monitor iosad_decoder_monitor_i (.core_clk(core_clk), .rst_n(rst_n),
  .clk_en(clk_en), .req(req), .rsp(rsp), .ext_sel(ext_sel), .ext_we(ext_we), .ext_addr(ext_addr),
  .ext_wdata(ext_wdata), .ext_rdata(ext_rdata), .port_d_out(port_d_out), .reg_image(reg_image));
`default_nettype wire

// >>> dv/tb_top.sv
// testbench: core model issues accesses, a byte model predicts the stored register reads
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  localparam iosad_pkg::iosad_op_t OP_PRD = iosad_pkg::IOSAD_OP_PORT_READ;
  localparam iosad_pkg::iosad_op_t OP_PWR = iosad_pkg::IOSAD_OP_PORT_WRITE;
  localparam iosad_pkg::iosad_op_t OP_SET = iosad_pkg::IOSAD_OP_SET_BIT;
  localparam iosad_pkg::iosad_op_t OP_CLR = iosad_pkg::IOSAD_OP_CLEAR_BIT;
  localparam iosad_pkg::iosad_op_t OP_TST = iosad_pkg::IOSAD_OP_TEST_BIT;
  localparam iosad_pkg::iosad_op_t OP_MRD = iosad_pkg::IOSAD_OP_MEM_READ;
  localparam iosad_pkg::iosad_op_t OP_MWR = iosad_pkg::IOSAD_OP_MEM_WRITE;
  // writable registers: address in the upper byte, implemented bits in the lower
  localparam logic [15:0] RW_TBL [23] = '{16'h04FF, 16'h05FF, 16'h07C0, 16'h08C0, 16'h0AFF, 16'h0BFF, 16'h0D44,
    16'h0E44, 16'h10F3, 16'h11F3, 16'h20FF, 16'h21FF, 16'h2203, 16'h24F3, 16'h26FF, 16'h27FF, 16'h28FF, 16'h2AFF,
    16'h2BFF, 16'h2CFF, 16'h31FF, 16'h32FF, 16'h330F};
  // flag registers: address, flag bits, bit aimed at by the bit op
  localparam logic [19:0] FLG_TBL [3] = '{20'h15070, 20'h162F0, 20'h19E42};
  localparam logic [7:0] PIN_MASK [5] = '{8'hFF, 8'hC0, 8'hFF, 8'h44, 8'hF3};
  logic core_clk;
  logic rst_n;
  logic clk_en;
  logic [7:0] ext_rdata;
  logic [7:0] pins [5];
  logic [7:0] fset [5];
  logic [7:0] pout [10];
  logic [255:0] reg_image;
  iosad_pkg::iosad_req_t req;
  iosad_pkg::iosad_rsp_t rsp;
  iosad_pkg::iosad_rsp_t ans;
  logic [7:0] mdl [64];
  logic [7:0] d;
  int a;
  int b;
  int err_count;
  int total_checks;
  int seed;
  bit ok;

  iosad_core_model iosad_core_model_i (.core_clk(core_clk), .req(req), .rsp(rsp));
  iosad_decoder iosad_decoder_i (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .req(req), .rsp(rsp),
    .ext_sel(), .ext_we(), .ext_addr(), .ext_wdata(), .ext_rdata(ext_rdata), .pin_b(pins[0]), .pin_c(pins[1]),
    .pin_d(pins[2]), .pin_e(pins[3]), .pin_f(pins[4]), .timer0_flag_set(fset[0]), .timer1_flag_set(fset[1]),
    .timer4_flag_set(fset[2]), .comparator_flag_set(fset[3]), .serial_flag_set(fset[4]), .comparator_out(1'b0),
    .pll_locked(1'b0), .serial_rx_data(8'h00), .serial_rx_load(1'b0), .port_b_dir(pout[0]), .port_b_out(pout[1]),
    .port_c_dir(pout[2]), .port_c_out(pout[3]), .port_d_dir(pout[4]), .port_d_out(pout[5]), .port_e_dir(pout[6]),
    .port_e_out(pout[7]), .port_f_dir(pout[8]), .port_f_out(pout[9]), .reg_image(reg_image));

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : summarize

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic go(input iosad_pkg::iosad_op_t op, input logic [8:0] ad, input logic [2:0] bs = 3'h0,
                    input logic [7:0] wd = 8'h00);
    iosad_core_model_i.access(op, ad, bs, wd, {$random(seed)} % 3, ans, ok);
    if (!ok) begin
      err_count++;
      $display("[ERR] %0t no answer", $time);
      summarize();
    end
  endtask : go

  task automatic raise(input int k);
    @(posedge core_clk);
    fset[k] <= 8'hFF;
    @(posedge core_clk);
    fset[k] <= 8'h00;
  endtask : raise

  initial begin
    seed = 32'heab454c6;
    rst_n = 1'b0;
    clk_en = 1'b1;
    ext_rdata = 8'h00;
    pins = '{default: 8'h00};
    fset = '{default: 8'h00};
    mdl = '{default: 8'h00};
    err_count = 0;
    total_checks = 0;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    for (a = 0; a < 64; a++) begin
      go(OP_PRD, 9'(a));
      check(ans.rdata, 8'h00);
    end
    for (b = 0; b < 23; b++) begin
      a = int'(RW_TBL[b][15:8]);
      d = 8'($random(seed)) & RW_TBL[b][7:0]; // defined bits and places only
      go(b % 2 ? OP_PWR : OP_MWR, b % 2 ? 9'(a) : 9'(a) + iosad_pkg::IOSAD_DATA_OFFSET, 3'h0, d);
      mdl[a] = d;
      go(OP_MRD, 9'(a) + iosad_pkg::IOSAD_DATA_OFFSET);
      check(ans.rdata, mdl[a]);
      go(OP_PRD, 9'(a));
      check(ans.rdata, mdl[a]);
      if (a >= 32) check(reg_image[(a - 32) * 8 +: 8], mdl[a]);
    end
    for (b = 0; b < 10; b++) begin
      a = int'(RW_TBL[b][15:8]);
      for (int k = 0; k < 8; k++) begin
        if (RW_TBL[b][k]) begin
          d[0] = 1'($random(seed));
          go(d[0] ? OP_SET : OP_CLR, 9'(a), 3'(k));
          mdl[a][k] = d[0];
          go(OP_TST, 9'(a), 3'(k));
          check(8'(ans.bit_value), 8'(mdl[a][k]));
        end
      end
      go(OP_PRD, 9'(a));
      check(ans.rdata, mdl[a]);
      check(pout[b], mdl[a]);
    end
    go(mdl[36][0] ? OP_CLR : OP_SET, 9'h024);
    check(8'(ans.hit), 8'h00);
    go(OP_PRD, 9'h024);
    check(ans.rdata, mdl[36]);
    for (b = 0; b < 3; b++) begin
      a = int'(FLG_TBL[b][19:12]);
      raise(b);
      go(OP_PRD, 9'(a));
      check(ans.rdata, FLG_TBL[b][11:4]);
      d = 8'($random(seed)) & FLG_TBL[b][11:4];
      go(OP_PWR, 9'(a), 3'h0, d);
      go(OP_PRD, 9'(a));
      check(ans.rdata, FLG_TBL[b][11:4] & ~d);
      raise(b);
      go(OP_SET, 9'(a), FLG_TBL[b][2:0]);
      go(OP_PRD, 9'(a));
      check(ans.rdata, 8'h00);
    end
    for (b = 3; b < 5; b++) begin
      a = int'(b == 3 ? iosad_pkg::IOSAD_COMPARATOR_CONTROL_STATUS : iosad_pkg::IOSAD_SERIAL_PERIPH_STATUS);
      d = b == 3 ? iosad_pkg::IOSAD_W1C_COMPARATOR : iosad_pkg::IOSAD_W1C_SERIAL_PERIPH_STATUS;
      raise(b);
      go(OP_PRD, 9'(a));
      check(ans.rdata, d);
      go(OP_PWR, 9'(a), 3'h0, d);
      go(OP_PRD, 9'(a));
      check(ans.rdata, 8'h00);
    end
    @(posedge core_clk);
    for (b = 0; b < 5; b++) pins[b] <= 8'($random(seed));
    ext_rdata <= 8'($random(seed));
    clk_en <= 1'b0;
    repeat (3) @(posedge core_clk);
    clk_en <= 1'b1;
    repeat (4) @(posedge core_clk);
    for (b = 0; b < 5; b++) begin
      go(OP_PRD, 9'(3 * b + 3));
      check(ans.rdata, pins[b] & PIN_MASK[b]);
      go(OP_TST, 9'(3 * b + 3), 3'(b));
      check(8'(ans.bit_value), 8'(pins[b][b] & PIN_MASK[b][b]));
    end
    go(OP_MRD, 9'h060);
    check(ans.rdata, ext_rdata);
    go(OP_MRD, 9'h1FF);
    check(8'(ans.hit), 8'h01);
    go(OP_MWR, 9'h100, 3'h0, 8'h5A);
    go(OP_PRD, 9'h060);
    check(8'(ans.hit), 8'h00);
    go(OP_MRD, 9'h010);
    check(8'(ans.hit), 8'h00);
    go(OP_TST, 9'h030);
    check(8'(ans.hit), 8'h00);
    go(OP_PRD, 9'h00B);
    check(ans.rdata, mdl[11]);
    summarize();
  end
endmodule : tb_top
`default_nettype wire
